// ---- csrc_defs.svh ----
/*
 * offsets, field positions, reset values and counts of the clock source
 * routing block. assumes inclusion by its bare name from the package and
 * the testbench.
 */
`ifndef CSRC_DEFS_SVH
`define CSRC_DEFS_SVH

// ****************************************
// register indexes, byte address is 4x
// ****************************************
`define CSRC_IDX_PLL 10'h010
`define CSRC_IDX_CAL 10'h018
`define CSRC_IDX_DIV 10'h1E0
`define CSRC_IDX_SRC 10'h1E1
`define CSRC_IDX_UPD 10'h232
`define CSRC_IDX_STAT 10'h233

// ****************************************
// field positions
// ****************************************
`define CSRC_PWR_MSB 1
`define CSRC_PWR_LSB 0
`define CSRC_PFD_BIT 7
`define CSRC_CAL_BIT 0
`define CSRC_DIV_MSB 2
`define CSRC_DIV_LSB 0
`define CSRC_BYP_BIT 0
`define CSRC_SRC_BIT 1
`define CSRC_UPD_BIT 0

// ****************************************
// reset values and codes
// ****************************************
`define CSRC_RST_PLL 8'h01
`define CSRC_RST_CAL 8'h00
`define CSRC_RST_DIV 8'h02
`define CSRC_RST_SRC 8'h00
`define CSRC_PWR_ON 2'b00
`define CSRC_PWR_ASYNC_DOWN 2'b01
`define CSRC_DIV_CODE_MAX 3'h4
`define CSRC_DIV_MIN 3'h2
`define CSRC_RESP_OKAY 2'b00
`define CSRC_RESP_SLVERR 2'b10

// ****************************************
// timing counts
// ****************************************
`define CSRC_CAL_CYCLES 8'h40

`endif

// ---- csrc_pkg.sv ----
/*
 * types and helpers of the clock source routing block.
 * assumes csrc_defs.svh is on the include path.
 */
`include "csrc_defs.svh"

package csrc_pkg;

    // ****************************************
    // routing fields that wait for commit
    // ****************************************
    typedef struct packed {
        logic bypassDiv;
        logic srcVco;
        logic [2:0] divCode;
        logic calReq;
    } csrc_route_type;

    // ****************************************
    // calibration state
    // ****************************************
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_RUN
    } csrc_cal_state_type;

    typedef struct packed {
        logic calBusy;
        logic calDone;
    } csrc_cal_stat_type;

    // ratio from code; codes beyond 4 saturate at divide-by-6
    function automatic logic [2:0] csrc_div_ratio(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `CSRC_DIV_CODE_MAX) ? `CSRC_DIV_CODE_MAX : code;
        csrc_div_ratio = c + `CSRC_DIV_MIN;
    endfunction : csrc_div_ratio

endpackage : csrc_pkg

// ---- csrc_commit_stage.sv ----
/*
 * active copy of the staged routing fields and the vco calibration run.
 * assumes a one-cycle commit pulse from the register slave.
 */
`timescale 1ns/1ns

module csrc_commit_stage (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // staged side
    input wire csrc_pkg::csrc_route_type staged,
    input wire logic commit,
    // active side
    output csrc_pkg::csrc_route_type active,
    output logic calStart,
    output csrc_pkg::csrc_cal_stat_type calStat
);
    import csrc_pkg::*;

    csrc_cal_state_type calState;
    logic [7:0] calCount;
    logic calEdge;

    // only a 0 to 1 step of the committed bit starts a run
    assign calEdge = commit && staged.calReq && !active.calReq;

    // ****************************************
    // active copy
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            active <= '{bypassDiv: 1'b0, srcVco: 1'b0,
                        divCode: 3'(`CSRC_RST_DIV), calReq: 1'b0};
        end else if (commit) begin
            active <= staged;
        end
    end

    // ****************************************
    // calibration run
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            calState <= CAL_IDLE;
            calCount <= 8'h00;
            calStart <= 1'b0;
            calStat <= '0;
        end else begin
            calStart <= calEdge;
            case (calState)
                CAL_IDLE: begin
                    if (calEdge) begin
                        calState <= CAL_RUN;
                        calCount <= `CSRC_CAL_CYCLES;
                        calStat <= '{calBusy: 1'b1, calDone: 1'b0};
                    end
                end
                CAL_RUN: begin
                    // a second request while running is dropped
                    if (calCount == 8'h01) begin
                        calState <= CAL_IDLE;
                        calStat <= '{calBusy: 1'b0, calDone: 1'b1};
                    end
                    calCount <= calCount - 8'h01;
                end
                default: begin
                    calState <= CAL_IDLE;
                end
            endcase
        end
    end

endmodule : csrc_commit_stage

// ---- csrc_clock_source_routing.sv ----
/*
 * register slave and routing controls of the clock source block.
 * assumes an axi4-lite master on clk, one write and one read at a time.
 */
// Added by the designer: register access over AXI4-Lite.
// What this block does
// - reset state: pll async down, divide-by-4, divider used, external clock selected
// - power-up and reset both restore those defaults over any programming
// - divider ratios 2 to 6 only, never below 2 when used
// - external input with pll on feeds the prescaler directly
// - external input selected keeps the internal vco powered off
// - power field 00b runs the pll, 01b powers it down
// - route bit 0 cleared feeds distribution from the vco divider
// - route bit 0 set bypasses the vco divider
// - route bit 1 cleared selects the external clock input
// - route bit 1 set selects the internal vco
// - polarity bit 0 positive, 1 negative; host matches its vco
// - calibration starts on committed 0 then 1 of the calibration bit
`timescale 1ns/1ns

module csrc_clock_source_routing (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pll controls
    output logic pllPowerDown,
    output logic pfdNegative,
    // routing controls
    output logic srcInternalVco,
    output logic vcoPowerOn,
    output logic divBypass,
    output logic [2:0] vcoDivRatio,
    output logic prescalerFromExtVco,
    // calibration
    output logic calStart,
    output logic calBusy
);
    import csrc_pkg::*;

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] pllReg;
    logic [7:0] calReg;
    logic [7:0] divReg;
    logic [7:0] srcReg;
    logic commitPulse;

    // ****************************************
    // bus state
    // ****************************************
    logic awHeld;
    logic wHeld;
    logic [9:0] wrIndex;
    logic [7:0] wrByte;
    logic wrLane0;
    logic doWrite;
    logic wrMapped;
    logic [9:0] rdIndex;

    csrc_route_type staged;
    csrc_route_type active;
    csrc_cal_stat_type calStat;

    // ****************************************
    // write channel handshakes
    // ****************************************
    // address and data held until both are in, response blocks new ones
    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    assign doWrite = awHeld && wHeld;
    assign arready = !rvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            wrIndex <= 10'h000;
        end else if (awvalid && awready) begin
            awHeld <= 1'b1;
            wrIndex <= awaddr[11:2];
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wrByte <= 8'h00;
            wrLane0 <= 1'b0;
        end else if (wvalid && wready) begin
            wHeld <= 1'b1;
            wrByte <= wdata[7:0];
            wrLane0 <= wstrb[0];
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    // ****************************************
    // write decode
    // ****************************************
    function automatic logic csrc_is_writable(input logic [9:0] idx);
        csrc_is_writable = (idx == `CSRC_IDX_PLL) || (idx == `CSRC_IDX_CAL) ||
                           (idx == `CSRC_IDX_DIV) || (idx == `CSRC_IDX_SRC) ||
                           (idx == `CSRC_IDX_UPD);
    endfunction : csrc_is_writable

    assign wrMapped = csrc_is_writable(wrIndex);

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid <= 1'b0;
        end else if (doWrite) begin
            bvalid <= 1'b1;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // unmapped and read-only targets answer with an error
    always_ff @(posedge clk) begin
        if (rst) begin
            bresp <= `CSRC_RESP_OKAY;
        end else if (doWrite) begin
            bresp <= wrMapped ? `CSRC_RESP_OKAY : `CSRC_RESP_SLVERR;
        end
    end

    // ****************************************
    // pll power and polarity, immediate effect
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pllReg <= `CSRC_RST_PLL;
        end else if (doWrite && wrLane0 && wrIndex == `CSRC_IDX_PLL) begin
            pllReg <= wrByte;
        end
    end

    // ****************************************
    // staged fields, held until commit
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            calReg <= `CSRC_RST_CAL;
        end else if (doWrite && wrLane0 && wrIndex == `CSRC_IDX_CAL) begin
            calReg <= {7'h00, wrByte[`CSRC_CAL_BIT]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            divReg <= `CSRC_RST_DIV;
        end else if (doWrite && wrLane0 && wrIndex == `CSRC_IDX_DIV) begin
            divReg <= {5'h00, wrByte[`CSRC_DIV_MSB:`CSRC_DIV_LSB]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            srcReg <= `CSRC_RST_SRC;
        end else if (doWrite && wrLane0 && wrIndex == `CSRC_IDX_SRC) begin
            srcReg <= {6'h00, wrByte[`CSRC_SRC_BIT], wrByte[`CSRC_BYP_BIT]};
        end
    end

    // update bit self-clears, so it always reads back 0
    always_ff @(posedge clk) begin
        if (rst) begin
            commitPulse <= 1'b0;
        end else begin
            commitPulse <= doWrite && wrLane0 && wrIndex == `CSRC_IDX_UPD &&
                           wrByte[`CSRC_UPD_BIT];
        end
    end

    assign staged = '{bypassDiv: srcReg[`CSRC_BYP_BIT],
                      srcVco: srcReg[`CSRC_SRC_BIT],
                      divCode: divReg[`CSRC_DIV_MSB:`CSRC_DIV_LSB],
                      calReq: calReg[`CSRC_CAL_BIT]};

    csrc_commit_stage i_csrc_commit_stage (
        .clk(clk),
        .rst(rst),
        .staged(staged),
        .commit(commitPulse),
        .active(active),
        .calStart(calStart),
        .calStat(calStat)
    );

    // ****************************************
    // routing outputs from active fields and the pll register
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pllPowerDown <= 1'b1;
        end else begin
            // codes other than 00b keep the pll down, the safe reading
            pllPowerDown <= pllReg[`CSRC_PWR_MSB:`CSRC_PWR_LSB] != `CSRC_PWR_ON;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pfdNegative <= 1'b0;
        end else begin
            pfdNegative <= pllReg[`CSRC_PFD_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            srcInternalVco <= 1'b0;
            vcoPowerOn <= 1'b0;
        end else begin
            srcInternalVco <= active.srcVco;
            vcoPowerOn <= active.srcVco;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            divBypass <= 1'b0;
            vcoDivRatio <= csrc_div_ratio(3'(`CSRC_RST_DIV));
        end else begin
            divBypass <= active.bypassDiv;
            vcoDivRatio <= csrc_div_ratio(active.divCode);
        end
    end

    // the external vco feeds the prescaler only while the pll runs
    always_ff @(posedge clk) begin
        if (rst) begin
            prescalerFromExtVco <= 1'b0;
        end else begin
            prescalerFromExtVco <= !active.srcVco &&
                pllReg[`CSRC_PWR_MSB:`CSRC_PWR_LSB] == `CSRC_PWR_ON;
        end
    end

    assign calBusy = calStat.calBusy;

    // ****************************************
    // read channel
    // ****************************************
    assign rdIndex = araddr[11:2];

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'b0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
            rresp <= `CSRC_RESP_OKAY;
        end else if (arvalid && arready) begin
            rresp <= `CSRC_RESP_OKAY;
            case (rdIndex)
                `CSRC_IDX_PLL: rdata <= {24'h00_0000, pllReg};
                `CSRC_IDX_CAL: rdata <= {24'h00_0000, calReg};
                `CSRC_IDX_DIV: rdata <= {24'h00_0000, divReg};
                `CSRC_IDX_SRC: rdata <= {24'h00_0000, srcReg};
                `CSRC_IDX_UPD: rdata <= 32'h0000_0000;
                `CSRC_IDX_STAT: begin
                    rdata <= {24'h00_0000, active.divCode, active.bypassDiv,
                              active.srcVco, pllPowerDown,
                              calStat.calDone, calStat.calBusy};
                end
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `CSRC_RESP_SLVERR;
                end
            endcase
        end
    end

endmodule : csrc_clock_source_routing

// ---- csrc_routing_chk.sv ----
/* port checker of the routing block.
   assumes bind to csrc_clock_source_routing, one clock. */
`timescale 1ns/1ns

module csrc_routing_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // routing
    input wire logic pllPowerDown,
    input wire logic srcInternalVco,
    input wire logic vcoPowerOn,
    input wire logic divBypass,
    input wire logic [2:0] vcoDivRatio,
    input wire logic prescalerFromExtVco,
    input wire logic calStart,
    input wire logic calBusy
);
    logic [6:0] busyLen;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // counts busy cycles; a stuck counter would hide a short run
    always_ff @(posedge clk) begin
        if (rst || !calBusy) begin
            busyLen <= 7'h00;
        end else begin
            busyLen <= busyLen + 7'h01;
        end
    end

    sequence calHold;
        calBusy ##1 (calBusy && !calStart);
    endsequence

    AST_RESET_STATE: assert property ($past(rst) |-> pllPowerDown && vcoDivRatio == 3'h4
        && !divBypass && !srcInternalVco && !vcoPowerOn) else $error("reset state wrong");
    AST_DIV_RANGE: assert property (vcoDivRatio >= 3'h2 && vcoDivRatio <= 3'h6)
        else $error("divider ratio out of range");
    AST_VCO_OFF: assert property (!srcInternalVco |-> !vcoPowerOn)
        else $error("vco powered with external source");
    AST_PRESCALER: assert property (prescalerFromExtVco == (!srcInternalVco && !pllPowerDown))
        else $error("prescaler feed wrong");
    AST_CAL_START: assert property (calStart |-> calHold)
        else $error("calibration start not one pulse");
    AST_CAL_RISE: assert property ($rose(calBusy) |-> calStart)
        else $error("busy without start");
    AST_CAL_LEN: assert property ($fell(calBusy) |-> busyLen == 7'h40)
        else $error("calibration length wrong");
    AST_COMMIT_ONLY: assert property ($changed({divBypass, srcInternalVco, vcoDivRatio})
        |-> $past(bvalid, 2)) else $error("routing changed without a write");
    AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_B_REFUSE: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answering");
endmodule : csrc_routing_chk

bind csrc_clock_source_routing csrc_routing_chk i_csrc_routing_chk (.clk(clk), .rst(rst),
    .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .rdata(rdata), .rvalid(rvalid), .rready(rready), .pllPowerDown(pllPowerDown),
    .srcInternalVco(srcInternalVco), .vcoPowerOn(vcoPowerOn), .divBypass(divBypass),
    .vcoDivRatio(vcoDivRatio), .prescalerFromExtVco(prescalerFromExtVco),
    .calStart(calStart), .calBusy(calBusy));

// ---- csrc_ext_source.sv ----
/* behavioural model of the clock source beyond the block.
   assumes it watches the block's routing outputs. */
`timescale 1ns/1ns

module csrc_ext_source #(
    parameter int EXT_MHZ = 2400,
    parameter int VCO_MHZ = 2400
) (
    // routing controls
    input wire logic srcInternalVco,
    input wire logic vcoPowerOn,
    input wire logic divBypass,
    input wire logic [2:0] vcoDivRatio,
    // rate at the channel dividers
    output int distMhz
);
    int srcMhz;

    // an unpowered vco gives no clock
    assign srcMhz = srcInternalVco ? (vcoPowerOn ? VCO_MHZ : 0) : EXT_MHZ;
    // only safe while the host never bypasses a fast source
    assign distMhz = divBypass ? srcMhz : srcMhz / int'(vcoDivRatio);
endmodule : csrc_ext_source

// ---- csrc_tb.sv ----
/* self-checking bench of the routing block.
   assumes design, checker and source model compiled first. */
`timescale 1ns/1ns
`include "csrc_defs.svh"

module tb;
    import csrc_pkg::*;
    localparam logic [11:0] A_PLL = {`CSRC_IDX_PLL, 2'b00};
    localparam logic [11:0] A_CAL = {`CSRC_IDX_CAL, 2'b00};
    localparam logic [11:0] A_DIV = {`CSRC_IDX_DIV, 2'b00};
    localparam logic [11:0] A_SRC = {`CSRC_IDX_SRC, 2'b00};
    localparam logic [11:0] A_UPD = {`CSRC_IDX_UPD, 2'b00};
    localparam logic [11:0] A_STAT = {`CSRC_IDX_STAT, 2'b00};
    // slow enough to pass the divider by, fast enough to need it with the vco
    localparam int EXT_MHZ = 1200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h1;
    logic [3:0] strb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pllPowerDown, pfdNegative;
    logic srcInternalVco, vcoPowerOn, divBypass, prescalerFromExtVco, calStart, calBusy;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] vcoDivRatio;
    int distMhz;
    int n_mismatch = 0;
    int checked = 0;

    always #25 clk = ~clk;

    csrc_clock_source_routing i_csrc_clock_source_routing (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pllPowerDown(pllPowerDown),
        .pfdNegative(pfdNegative), .srcInternalVco(srcInternalVco), .vcoPowerOn(vcoPowerOn),
        .divBypass(divBypass), .vcoDivRatio(vcoDivRatio),
        .prescalerFromExtVco(prescalerFromExtVco), .calStart(calStart), .calBusy(calBusy));

    csrc_ext_source #(.EXT_MHZ(EXT_MHZ)) i_csrc_ext_source (.srcInternalVco(srcInternalVco),
        .vcoPowerOn(vcoPowerOn), .divBypass(divBypass), .vcoDivRatio(vcoDivRatio),
        .distMhz(distMhz));

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // hold delays the response ready, so the slave must stand its answer
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er,
        input int hold);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (hold == 0);
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n >= hold) bready <= 1'b1;
        end while (!(bvalid && bready) && n < 200);
        chk({bresp, n < 200}, {er, 1'b1});
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er,
        input int hold);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (hold == 0);
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n >= hold) rready <= 1'b1;
        end while (!(rvalid && rready) && n < 200);
        chk({rresp, n < 200, rdata}, {er, 1'b1, ed});
        rready <= 1'b0;
    endtask : rd

    task automatic commit();
        wr(A_UPD, 8'h01, 2'b00, 0);
        repeat (3) @(posedge clk);
    endtask : commit

    task automatic calTry(input int exp);
        int s;
        s = 0;
        wr(A_UPD, 8'h01, 2'b00, 0);
        repeat (8) begin
            @(posedge clk);
            if (calStart === 1'b1) s++;
        end
        chk(s, exp);
        for (int i = 0; i < 100 && calBusy !== 1'b0; i++) @(posedge clk);
        chk(calBusy, 1'b0);
    endtask : calTry

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        #(20000 * 50);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(A_PLL, 8'h01, 2'b00, 0);
        rd(A_DIV, 8'h02, 2'b00, 0);
        rd(A_SRC, 8'h00, 2'b00, 0);
        chk({pllPowerDown, vcoDivRatio, divBypass, srcInternalVco, vcoPowerOn}, 7'h60);
        $display("test reset done");
        wr(A_PLL, 8'h00, 2'b00, 0);
        @(posedge clk);
        chk({pllPowerDown, prescalerFromExtVco}, 2'b01);
        wr(A_PLL, 8'h81, 2'b00, 2);
        @(posedge clk);
        chk({pllPowerDown, pfdNegative, prescalerFromExtVco}, 3'b110);
        strb = 4'hE;
        wr(A_PLL, 8'h00, 2'b00, 0);
        strb = 4'h1;
        rd(A_PLL, 8'h81, 2'b00, 0);
        wr(A_PLL, 8'h00, 2'b00, 0);
        $display("test power done");
        // external source slow enough to bypass the divider
        wr(A_SRC, 8'h01, 2'b00, 0);
        wr(A_DIV, 8'h00, 2'b00, 0);
        repeat (3) @(posedge clk);
        chk({srcInternalVco, divBypass, vcoDivRatio}, 5'h04);
        commit();
        chk({srcInternalVco, vcoPowerOn, divBypass, vcoDivRatio, prescalerFromExtVco}, 7'h15);
        rd(A_STAT, 8'h10, 2'b00, 0);
        chk(distMhz, EXT_MHZ);
        $display("test staging done");
        wr(A_SRC, 8'h00, 2'b00, 0);
        for (int c = 0; c < 8; c++) begin
            wr(A_DIV, 8'(c), 2'b00, 0);
            commit();
            chk({srcInternalVco, divBypass, vcoDivRatio}, {2'b00, (c > 4) ? 3'h6 : 3'(c + 2)});
        end
        chk(distMhz, EXT_MHZ / 6);
        $display("test divider done");
        wr(A_SRC, 8'h02, 2'b00, 0);
        wr(A_CAL, 8'h01, 2'b00, 0);
        calTry(1);
        calTry(0);
        wr(A_CAL, 8'h00, 2'b00, 0);
        calTry(0);
        wr(A_CAL, 8'h01, 2'b00, 0);
        calTry(1);
        chk({srcInternalVco, vcoPowerOn, divBypass}, 3'b110);
        rd(A_STAT, 8'hEA, 2'b00, 0);
        $display("test calibration done");
        rd(12'hFFC, 32'h0000_0000, 2'b10, 3);
        wr(12'hFFC, 8'h5A, 2'b10, 0);
        wr(A_STAT, 8'hFF, 2'b10, 3);
        rd(A_UPD, 8'h00, 2'b00, 0);
        $display("test bus done");
        wr(A_SRC, 8'h01, 2'b00, 0);
        wr(A_PLL, 8'h80, 2'b00, 0);
        commit();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({pllPowerDown, pfdNegative, srcInternalVco, divBypass, vcoDivRatio}, 7'h44);
        rd(A_PLL, 8'h01, 2'b00, 0);
        rd(A_SRC, 8'h00, 2'b00, 0);
        $display("test second reset done");
        test_done();
    end
endmodule : tb
